// ### rtl/rrcx_pkg.sv
// Package with opcode fields and datapath constants for the rotate-right-through-carry unit
package rrcx_pkg;
  // ==========================================================
  // Instruction word layout
  localparam int unsigned RRCX_INSN_W = 12;
  localparam int unsigned RRCX_DATA_W = 8;
  localparam int unsigned RRCX_ADDR_W = 5;
  localparam int unsigned RRCX_NUM_LOC = 32;
  localparam int unsigned RRCX_OPC_HI = 11;
  localparam int unsigned RRCX_OPC_LO = 6;
  localparam int unsigned RRCX_DEST_BIT = 5;
  localparam logic [5:0] RRCX_OPC_VAL = 6'h0c;
  localparam logic RRCX_DEST_ACC = 1'b0;
  localparam logic RRCX_DEST_MEM = 1'b1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RRCX_ACC_RST = 8'h00;
  localparam logic [7:0] RRCX_MEM_RST = 8'h00;
  localparam logic RRCX_FLAG_RST = 1'b0;
endpackage : rrcx_pkg

// ### rtl/rrcx_rotate.sv
// Combinational rotate-right-through-carry slice
`timescale 1ns/1ps
module rrcx_rotate
  import rrcx_pkg::*;
#(
  parameter int unsigned DATA_W = RRCX_DATA_W
) (
  input wire logic [DATA_W-1:0] data_i,
  input wire logic carry_i,
  output logic [DATA_W-1:0] data_o,
  output logic carry_o
);
  // ==========================================================
  // Parameter check
  // A one-bit word has nothing to rotate through
  if (DATA_W < 2) begin : g_bad_width
    $error("DATA_W must be at least 2");
  end

  // ==========================================================
  // Rotation: carry enters the top, bit 0 leaves into carry
  assign data_o = {carry_i, data_i[DATA_W-1:1]};
  assign carry_o = data_i[0];
endmodule : rrcx_rotate

// ### rtl/rrcx_exec.sv
// Execution unit for the rotate-right-through-carry instruction with its file and flags
// Operation
// - Decode 0011 00df ffff; f addresses 0..31
// - Shift right; carry in at bit 7, bit 0 out
// - d=0 writes accumulator, memory untouched
// - d=1 writes back to source location
`timescale 1ns/1ps
module rrcx_exec
  import rrcx_pkg::*;
#(
  parameter int unsigned NUM_LOC = RRCX_NUM_LOC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic insn_valid_i,
  input wire logic [RRCX_INSN_W-1:0] insn_i,
  input wire logic mem_we_i,
  input wire logic [RRCX_ADDR_W-1:0] mem_waddr_i,
  input wire logic [RRCX_DATA_W-1:0] mem_wdata_i,
  input wire logic [RRCX_ADDR_W-1:0] mem_raddr_i,
  output logic [RRCX_DATA_W-1:0] mem_rdata_o,
  output logic [RRCX_DATA_W-1:0] acc_o,
  output logic carry_o,
  output logic zero_o,
  output logic digit_carry_o,
  output logic op_hit_o,
  output logic done_o
);
  // ==========================================================
  // Parameter checks
  // The five address bits of the instruction reach at most this many cells
  if ((NUM_LOC < 1) || (NUM_LOC > (1 << RRCX_ADDR_W))) begin : g_bad_depth
    $error("NUM_LOC must lie between 1 and the instruction address range");
  end

  // ==========================================================
  // Helper functions
  // True when an address names a cell that this build really holds
  function automatic logic cell_ok(input logic [RRCX_ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    return (wide < NUM_LOC);
  endfunction : cell_ok

  // Reference rotation for the checkers, kept apart from the datapath slice
  function automatic logic [RRCX_DATA_W-1:0] rot_ref(
    input logic [RRCX_DATA_W-1:0] data, input logic carry);
    return {carry, data[RRCX_DATA_W-1:1]};
  endfunction : rot_ref

  // ==========================================================
  // Decode
  // Other opcodes are ignored here; the rest of the core owns them
  logic rotate_right_through_carry_op;
  logic dest_sel;
  logic [RRCX_ADDR_W-1:0] src_addr;
  logic src_ok;
  assign rotate_right_through_carry_op = insn_valid_i &&
    (insn_i[RRCX_OPC_HI:RRCX_OPC_LO] == RRCX_OPC_VAL);
  assign dest_sel = insn_i[RRCX_DEST_BIT];
  assign src_addr = insn_i[RRCX_ADDR_W-1:0];
  assign src_ok = cell_ok(src_addr);
  assign op_hit_o = rotate_right_through_carry_op;

  // ==========================================================
  // Data memory, accumulator and flags
  // Limitation: the cells have no reset, so software must load them first
  logic [RRCX_DATA_W-1:0] mem_r [NUM_LOC];
  logic [RRCX_DATA_W-1:0] acc_r;
  logic carry_r;
  logic zero_r;
  logic dc_r;
  logic done_r;
  logic [RRCX_DATA_W-1:0] src_data;
  logic [RRCX_DATA_W-1:0] rot_data;
  logic rot_carry;

  // Operand fetch; a missing cell reads as the reset value instead of unknown
  assign src_data = src_ok ? mem_r[src_addr] : RRCX_MEM_RST;

  // Shared rotation slice
  rrcx_rotate #(
    .DATA_W(RRCX_DATA_W)
  ) u_rot (
    .data_i(src_data),
    .carry_i(carry_r),
    .data_o(rot_data),
    .carry_o(rot_carry)
  );

  // ==========================================================
  // Write enables
  // The instruction wins over an outside write to the same cell
  logic acc_we;
  logic rot_mem_we;
  logic ext_we;
  assign acc_we = rotate_right_through_carry_op && (dest_sel == RRCX_DEST_ACC);
  assign rot_mem_we = rotate_right_through_carry_op && (dest_sel == RRCX_DEST_MEM) &&
    src_ok;

  // Outside writes to any other cell still land in the same cycle
  assign ext_we = mem_we_i && cell_ok(mem_waddr_i) &&
    !(rot_mem_we && (mem_waddr_i == src_addr));

  // ==========================================================
  // Sequential state
  // Accumulator, carry and completion strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= RRCX_ACC_RST;
      carry_r <= RRCX_FLAG_RST;
      zero_r <= RRCX_FLAG_RST;
      dc_r <= RRCX_FLAG_RST;
      done_r <= 1'b0;
    end else begin
      if (acc_we) begin
        acc_r <= rot_data;
      end
      if (rotate_right_through_carry_op) begin
        carry_r <= rot_carry;
      end
      done_r <= rotate_right_through_carry_op;
    end
  end

  // Memory cells: reset-free storage keeps the array cheap
  // Separate enables let a write-back and an outside write land together
  always_ff @(posedge clk_i) begin
    if (rot_mem_we) begin
      mem_r[src_addr] <= rot_data;
    end
    if (ext_we) begin
      mem_r[mem_waddr_i] <= mem_wdata_i;
    end
  end

  // ==========================================================
  // Outputs
  // All outputs but the read port and op_hit_o come straight from registers
  assign mem_rdata_o = cell_ok(mem_raddr_i) ? mem_r[mem_raddr_i] : RRCX_MEM_RST;
  assign acc_o = acc_r;
  assign carry_o = carry_r;
  assign zero_o = zero_r;
  assign digit_carry_o = dc_r;
  assign done_o = done_r;

  // ==========================================================
  // Assertions
  // All checks pause while reset is low; memory checks expect a loaded array
  // Carry must take the old bit 0 of the operand
  a_carry_from_bit0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rotate_right_through_carry_op |=> carry_r == $past(src_data[0]))
    else $error("carry did not take old bit 0");

  // Accumulator result against the reference rotation
  a_acc_rotated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    acc_we |=> acc_r == rot_ref($past(src_data), $past(carry_r)))
    else $error("accumulator result wrong");

  // Source cell keeps its value when the result goes to the accumulator
  a_mem_untouched: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (acc_we && src_ok && !(mem_we_i && mem_waddr_i == src_addr))
    |=> mem_r[$past(src_addr)] == $past(src_data))
    else $error("memory changed on accumulator write");

  // A cell that nothing writes keeps its value
  a_cell_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_ok && !rot_mem_we && !(ext_we && (mem_waddr_i == src_addr)))
    |=> mem_r[$past(src_addr)] == $past(src_data))
    else $error("unwritten cell changed");

  // Write-back lands in the source cell
  a_mem_writeback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rot_mem_we |=> mem_r[$past(src_addr)] == rot_ref($past(src_data), $past(carry_r)))
    else $error("memory write-back wrong");

  // On a same-cell clash the write-back, not the outside data, ends up stored
  a_write_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rot_mem_we && mem_we_i && (mem_waddr_i == src_addr))
    |=> mem_r[$past(src_addr)] == rot_ref($past(src_data), $past(carry_r)))
    else $error("outside write beat the write-back");

  // Outside write lands wherever no write-back claims the cell
  a_ext_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_we |=> mem_r[$past(mem_waddr_i)] == $past(mem_wdata_i))
    else $error("outside write lost");

  // Accumulator holds during a write-back
  a_acc_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rot_mem_we |=> $stable(acc_r))
    else $error("accumulator changed on write-back");

  // Accumulator moves only on a rotate with d=0
  a_acc_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !acc_we |=> $stable(acc_r))
    else $error("accumulator changed without a rotate");

  // Zero and digit-carry flags are never touched
  a_flags_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rotate_right_through_carry_op |=> $stable(zero_r) && $stable(dc_r))
    else $error("zero or digit carry changed");

  // Carry moves only on a rotate
  a_carry_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rotate_right_through_carry_op |=> $stable(carry_r))
    else $error("carry changed without a rotate");

  // Done rises the cycle after every rotate
  a_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rotate_right_through_carry_op |=> done_r)
    else $error("not done in one cycle");

  // Done stays low after any cycle without a rotate
  a_done_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rotate_right_through_carry_op |=> !done_r)
    else $error("done without a rotate");

  // Decode hits only the pattern, checked as bits 11:8 and bits 7:6
  a_decode_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_hit_o |-> insn_valid_i && (insn_i[11:8] == 4'h3) && (insn_i[7:6] == 2'h0))
    else $error("decode hit on wrong pattern");

  // Every valid word of the pattern is decoded
  a_decode_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (insn_valid_i && (insn_i[11:8] == 4'h3) && (insn_i[7:6] == 2'h0)) |-> op_hit_o)
    else $error("decode missed the pattern");
endmodule : rrcx_exec

// ### tb/rrcx_exec_test.sv
// Self-checking bench for the rotate-right-through-carry execution unit
`timescale 1ns/1ps
module rrcx_exec_test;
  import rrcx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic insn_valid_i = 1'b0;
  logic [RRCX_INSN_W-1:0] insn_i = 12'h000;
  logic mem_we_i = 1'b0;
  logic [RRCX_ADDR_W-1:0] mem_waddr_i = 5'h00;
  logic [RRCX_DATA_W-1:0] mem_wdata_i = 8'h00;
  logic [RRCX_ADDR_W-1:0] mem_raddr_i = 5'h00;
  logic [RRCX_DATA_W-1:0] mem_rdata_o, acc_o;
  logic carry_o, zero_o, digit_carry_o, op_hit_o, done_o;
  logic [7:0] mem_m [32];
  logic [7:0] acc_m = RRCX_ACC_RST;
  logic c_m = RRCX_FLAG_RST;
  logic [31:0] seed = 32'hfb3f8788;
  logic [31:0] w;
  int errors = 0;
  int check_count = 0;
  // ==========================================================
  // Clock and device
  always #5 clk_i = ~clk_i;
  rrcx_exec dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .mem_we_i(mem_we_i), .mem_waddr_i(mem_waddr_i),
    .mem_wdata_i(mem_wdata_i), .mem_raddr_i(mem_raddr_i), .mem_rdata_o(mem_rdata_o),
    .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .digit_carry_o(digit_carry_o),
    .op_hit_o(op_hit_o), .done_o(done_o));
  // ==========================================================
  // Helpers: xorshift source, compare, verdict
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // One cycle: drive just after the edge, model the edge, compare results
  task automatic step(input logic v, input logic [11:0] ins, input logic we,
                      input logic [4:0] wa, input logic [7:0] wd);
    logic hit;
    logic [7:0] r;
    logic nc;
    hit = v && (ins[11:6] == RRCX_OPC_VAL);
    r = {c_m, mem_m[ins[4:0]][7:1]};
    nc = mem_m[ins[4:0]][0];
    insn_valid_i = v;
    insn_i = ins;
    mem_we_i = we;
    mem_waddr_i = wa;
    mem_wdata_i = wd;
    mem_raddr_i = ins[4:0];
    #4 chk("op_hit", {7'h00, op_hit_o}, {7'h00, hit});
    @(posedge clk_i);
    // Instruction write-back wins over an outside write to the same cell
    if (we && !(hit && ins[5] && wa == ins[4:0])) mem_m[wa] = wd;
    if (hit && ins[5]) mem_m[ins[4:0]] = r;
    if (hit && !ins[5]) acc_m = r;
    if (hit) c_m = nc;
    #1;
    chk("acc", acc_o, acc_m);
    chk("mem", mem_rdata_o, mem_m[ins[4:0]]);
    chk("carry", {7'h00, carry_o}, {7'h00, c_m});
    chk("flags", {6'h00, zero_o, digit_carry_o}, {6'h00, RRCX_FLAG_RST, RRCX_FLAG_RST});
    chk("done", {7'h00, done_o}, {7'h00, hit});
  endtask : step
  // Mid-run reset: registers clear at once, memory keeps its contents
  task automatic mid_reset();
    insn_valid_i = 1'b0;
    mem_we_i = 1'b0;
    rst_n_i = 1'b0;
    #4;
    chk("acc_rst", acc_o, RRCX_ACC_RST);
    chk("carry_rst", {7'h00, carry_o}, {7'h00, RRCX_FLAG_RST});
    chk("done_rst", {7'h00, done_o}, 8'h00);
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    acc_m = RRCX_ACC_RST;
    c_m = RRCX_FLAG_RST;
    $display("Mid-run reset test done");
  endtask : mid_reset
  // ==========================================================
  // Memory is not reset, so preload every cell before random back-to-back traffic
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int i = 0; i < RRCX_NUM_LOC; i++) begin
      w = rnd();
      step(1'b0, 12'h000, 1'b1, i[4:0], w[7:0]);
    end
    $display("Preload test done");
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) begin
        mid_reset();
      end
      w = rnd();
      step(w[0] | w[1], w[2] ? {RRCX_OPC_VAL, w[13:8]} : w[19:8], w[3] & w[4],
           w[5] ? w[12:8] : w[24:20], w[31:24]);
    end
    $display("Random rotate test done");
    close_out();
  end
endmodule : rrcx_exec_test
